/* core/switch_defs.svh */
`ifndef SWITCH_DEFS_SVH
`define SWITCH_DEFS_SVH
`define NP 3
`define NQ 6
`define DW 32
`define WW 34
`define W_SOP 33
`define W_EOP 32
`define HDR_TC 29:27
`define HDR_BYID 26
`define HDR_XLAT 25
`define HDR_TGT 15:0
`define ID_BUS 15:8
`define TC_ZERO 3'h0
`define DEST_UP 2'h0
`define DEST_DROP 2'h3
`define QDEPTH 2'h2
`define LANES 4
`define CLK_NS 50
`define WIN_NS 1000
`define WIN_CYC ((`WIN_NS + `CLK_NS - 1) / `CLK_NS)
`define WIN_W 5
`define VC1_BUDGET 4'h8
`define IDLE_NS 2000
`define IDLE_CYC ((`IDLE_NS + `CLK_NS - 1) / `CLK_NS)
`define IDLE_W 6
`define REFCLK_DEF 5'h1f
`define REFCLK_RST 7'h1f
`endif

/* core/switch_pkg.sv */
package switch_pkg;
   typedef enum logic [2:0] {
      LK_L0 = 3'h0,
      LK_L0S = 3'h1,
      LK_L1 = 3'h2,
      LK_L23R = 3'h3,
      LK_L23 = 3'h4
   } link_e;
   typedef enum logic [2:0] {
      D_D0 = 3'h0,
      D_D1 = 3'h1,
      D_D2 = 3'h2,
      D_D3HOT = 3'h3,
      D_D3COLD = 3'h4
   } dstate_e;
   typedef logic [33:0] word_t;
endpackage : switch_pkg

/* core/three_port_packet_switch_core.sv */
`timescale 1ns/1ns
`include "switch_defs.svh"
module three_port_packet_switch_core (
   input wire logic clock,
   input wire logic srst,
   input wire logic system_reset_n,
   input wire logic [2:0] rx_valid,
   input wire logic [2:0][31:0] rx_data,
   input wire logic [2:0] rx_sop,
   input wire logic [2:0] rx_eop,
   output logic [2:0] rx_ready,
   output logic [2:0][2:0] rx_credit_vc0,
   output logic [2:0][2:0] rx_credit_vc1,
   output logic [2:0] tx_valid,
   output logic [2:0][31:0] tx_data,
   output logic [2:0] tx_sop,
   output logic [2:0] tx_eop,
   input wire logic [2:0] tx_ready,
   input wire logic vc1_enable,
   input wire logic peer_access_control,
   input wire logic address_translation_service,
   input wire logic [2:1][7:0] sec_bus,
   input wire logic [2:1][7:0] sub_bus,
   input wire logic [2:1][15:0] mem_base,
   input wire logic [2:1][15:0] mem_limit,
   input wire logic [11:0] lane_rx_active,
   input wire switch_pkg::dstate_e device_state,
   input wire logic [2:0] pme_turn_off,
   input wire logic [2:1] downstream_reset_ctl,
   output logic [2:1] downstream_port_reset_n,
   input wire logic clock_buffer_powerdown,
   input wire logic [7:6] eeprom_refclk_en,
   output logic [7:1] ref_clock_out_enable,
   output switch_pkg::link_e [2:0] link_state,
   output logic buffers_idle
);
   import switch_pkg::*;

   logic rst;
   logic [2:0] link_up;
   logic [2:0] rx_fire;
   logic [2:0] rx_vc;
   logic [2:0] xfer;
   word_t rx_word [`NP];
   word_t head [`NQ];
   word_t wdat [`NQ];
   word_t mem_q [`NQ][2];
   logic [`NQ-1:0] wr;
   logic [`NQ-1:0] rd;
   logic [`NQ-1:0] pop;
   logic [`NQ-1:0] drop;
   logic [`NQ-1:0] qok;
   logic [1:0] hdest [`NQ];
   logic [1:0] dest_q [`NQ];
   logic [1:0] cnt_q [`NQ];
   logic [1:0] cnt_d [`NQ];
   logic [`NQ-1:0] wp_q;
   logic [`NQ-1:0] rp_q;
   logic [2:0] cur_vc_q;
   logic [`NQ-1:0] req [`NP];
   logic [3:0] pk [`NP];
   logic [2:0] mv;
   word_t inw [`NP];
   logic [2:0] lock_q;
   logic [2:0] owner_q [`NP];
   logic [1:0] rr_q [`NP];
   logic [3:0] budget_q [`NP];
   logic [`WIN_W-1:0] win_q;
   logic win_end;
   logic [2:0] out_v_q;
   logic [2:0] sk_v_q;
   word_t out_w_q [`NP];
   word_t sk_w_q [`NP];
   logic [`IDLE_W-1:0] idle_q [`NP];
   link_e link_q [`NP];
   logic [2:0] rdy_q;
   logic [2:0][2:0] cr0_q;
   logic [2:0][2:0] cr1_q;
   logic [2:1] dn_rst_n_q;
   logic [7:1] refclk_q;
   logic idle_all_q;

   // Steering of one header word from a given ingress port
   function automatic logic [1:0] route(input logic [1:0] src, input logic [31:0] h,
                                        input logic peer_on, input logic xlat_on);
      logic [1:0] d;
      logic [2:1] hit;
      d = `DEST_UP;
      for (int p = 1; p < `NP; p++) begin
         hit[p] = h[`HDR_BYID] ?
            (h[`ID_BUS] >= sec_bus[p] && h[`ID_BUS] <= sub_bus[p]) :
            (h[`HDR_TGT] >= mem_base[p] && h[`HDR_TGT] <= mem_limit[p]);
      end
      if (hit[1]) begin
         d = 2'h1;
      end else if (hit[2]) begin
         d = 2'h2;
      end
      if (src != `DEST_UP && d != `DEST_UP && peer_on &&
          !(xlat_on && h[`HDR_XLAT])) begin
         d = `DEST_UP;
      end
      if (d == src) begin
         d = `DEST_DROP;
      end
      return d;
   endfunction : route

   // Round robin over ports, second channel first when allowed
   function automatic logic [3:0] pick(input logic [`NQ-1:0] r, input logic hi,
                                       input logic [1:0] rr);
      logic [3:0] res;
      int p;
      res = 4'h0;
      for (int v = 0; v < 2; v++) begin
         for (int k = `NP - 1; k >= 0; k--) begin
            p = (int'(rr) + k) % `NP;
            if (r[p*2+v] && (v == 0 || hi)) begin
               res = {1'b1, 3'(p*2+v)};
            end
         end
      end
      return res;
   endfunction : pick

   function automatic link_e next_link(input link_e s, input logic act, input logic idle,
                                       input logic turn_off, input dstate_e ds);
      link_e n;
      n = s;
      unique case (s)
         LK_L23: n = LK_L23;
         LK_L23R: n = (ds == D_D3COLD) ? LK_L23 : LK_L23R;
         LK_L0, LK_L0S, LK_L1: begin
            if (turn_off) begin
               n = LK_L23R;
            end else if (ds != D_D0) begin
               n = LK_L1;
            end else if (act) begin
               n = LK_L0;
            end else if (idle) begin
               n = LK_L0S;
            end
         end
         default: n = LK_L0;
      endcase
      return n;
   endfunction : next_link

   assign rst = srst | ~system_reset_n;
   assign rx_fire = rx_valid & rdy_q;
   assign win_end = win_q == `WIN_W'(`WIN_CYC - 1);

   genvar g;
   for (g = 0; g < `NP; g++) begin : gp
      assign link_up[g] = |lane_rx_active[g*`LANES +: `LANES];
      assign rx_word[g] = {rx_sop[g], rx_eop[g], rx_data[g]};
      assign rx_vc[g] = rx_sop[g] ? (vc1_enable & (rx_data[g][`HDR_TC] != `TC_ZERO)) :
                        cur_vc_q[g];
      assign xfer[g] = ~vc1_enable & (cnt_q[g*2+1] != 2'h0) & (cnt_q[g*2] != `QDEPTH);
      assign pk[g] = pick(req[g], budget_q[g] != 4'h0 || lock_q[g], rr_q[g]);
      assign mv[g] = pk[g][3] & ~sk_v_q[g] & link_up[g];
      assign inw[g] = head[pk[g][2:0]];
   end

   for (g = 0; g < `NQ; g++) begin : gq
      localparam int P = g / 2;
      assign head[g] = mem_q[g][rp_q[g]];
      assign qok[g] = (g % 2 == 0) | vc1_enable;
      assign hdest[g] = head[g][`W_SOP] ?
         route(2'(P), head[g][`DW-1:0], peer_access_control, address_translation_service) :
         dest_q[g];
      assign drop[g] = qok[g] & (cnt_q[g] != 2'h0) & (hdest[g] == `DEST_DROP);
      assign cnt_d[g] = cnt_q[g] + {1'b0, wr[g]} - {1'b0, rd[g]};
      if (g % 2 == 1) begin : gv1
         assign wr[g] = rx_fire[P] & (~vc1_enable | rx_vc[P]);
         assign wdat[g] = rx_word[P];
         assign rd[g] = pop[g] | xfer[P];
      end else begin : gv0
         assign wr[g] = vc1_enable ? rx_fire[P] & ~rx_vc[P] : xfer[P];
         assign wdat[g] = vc1_enable ? rx_word[P] : head[g+1];
         assign rd[g] = pop[g];
      end
      for (genvar e = 0; e < `NP; e++) begin : ge
         assign req[e][g] = qok[g] & (cnt_q[g] != 2'h0) & (hdest[g] == 2'(e)) &
            (lock_q[e] ? owner_q[e] == 3'(g) : head[g][`W_SOP]);
      end
   end

   always_comb begin
      pop = drop;
      for (int e = 0; e < `NP; e++) begin
         if (mv[e]) begin
            pop[pk[e][2:0]] = 1'b1;
         end
      end
   end

   // Ingress queue storage, one pair per port
   always_ff @(posedge clock) begin
      for (int i = 0; i < `NQ; i++) begin
         if (wr[i]) begin
            mem_q[i][wp_q[i]] <= wdat[i];
         end
      end
   end

   always_ff @(posedge clock) begin
      for (int i = 0; i < `NQ; i++) begin
         if (rst) begin
            wp_q[i] <= 1'b0;
            rp_q[i] <= 1'b0;
            cnt_q[i] <= 2'h0;
            dest_q[i] <= `DEST_UP;
         end else begin
            wp_q[i] <= wp_q[i] ^ wr[i];
            rp_q[i] <= rp_q[i] ^ rd[i];
            cnt_q[i] <= cnt_d[i];
            if (rd[i] && head[i][`W_SOP]) begin
               dest_q[i] <= hdest[i];
            end
         end
      end
   end

   // Ready and credits from this port's queues alone
   always_ff @(posedge clock) begin
      for (int p = 0; p < `NP; p++) begin
         if (rst) begin
            cur_vc_q[p] <= 1'b0;
            rdy_q[p] <= 1'b0;
            cr0_q[p] <= 3'h0;
            cr1_q[p] <= 3'h0;
         end else begin
            if (rx_fire[p] && rx_sop[p]) begin
               cur_vc_q[p] <= rx_vc[p];
            end
            rdy_q[p] <= (cnt_d[p*2] != `QDEPTH) && (cnt_d[p*2+1] != `QDEPTH);
            cr0_q[p] <= 3'(`QDEPTH - cnt_d[p*2]) +
                        (vc1_enable ? 3'h0 : 3'(`QDEPTH - cnt_d[p*2+1]));
            cr1_q[p] <= vc1_enable ? 3'(`QDEPTH - cnt_d[p*2+1]) : 3'h0;
         end
      end
   end

   // Egress lock, round robin and channel budget
   always_ff @(posedge clock) begin
      if (rst || win_end) begin
         win_q <= `WIN_W'(0);
      end else begin
         win_q <= win_q + `WIN_W'(1);
      end
   end

   always_ff @(posedge clock) begin
      for (int e = 0; e < `NP; e++) begin
         if (rst) begin
            lock_q[e] <= 1'b0;
            owner_q[e] <= 3'h0;
            rr_q[e] <= 2'h0;
            budget_q[e] <= `VC1_BUDGET;
         end else begin
            if (mv[e]) begin
               lock_q[e] <= ~inw[e][`W_EOP];
               owner_q[e] <= pk[e][2:0];
               if (!lock_q[e]) begin
                  rr_q[e] <= (pk[e][2:1] == 2'h2) ? 2'h0 : pk[e][2:1] + 2'h1;
               end
            end
            if (win_end) begin
               budget_q[e] <= `VC1_BUDGET;
            end else if (mv[e] && pk[e][0] && budget_q[e] != 4'h0) begin
               budget_q[e] <= budget_q[e] - 4'h1;
            end
         end
      end
   end

   // Two-entry egress buffer holding each word until taken
   always_ff @(posedge clock) begin
      for (int e = 0; e < `NP; e++) begin
         if (rst) begin
            out_v_q[e] <= 1'b0;
            sk_v_q[e] <= 1'b0;
            out_w_q[e] <= '0;
            sk_w_q[e] <= '0;
         end else if (!out_v_q[e] || tx_ready[e]) begin
            out_v_q[e] <= sk_v_q[e] | mv[e];
            out_w_q[e] <= sk_v_q[e] ? sk_w_q[e] : inw[e];
            sk_v_q[e] <= 1'b0;
         end else if (mv[e]) begin
            sk_v_q[e] <= 1'b1;
            sk_w_q[e] <= inw[e];
         end
      end
   end

   always_ff @(posedge clock) begin
      for (int p = 0; p < `NP; p++) begin
         if (rst) begin
            idle_q[p] <= `IDLE_W'(0);
            link_q[p] <= LK_L0;
         end else begin
            if (rx_valid[p] || out_v_q[p]) begin
               idle_q[p] <= `IDLE_W'(0);
            end else if (idle_q[p] != `IDLE_W'(`IDLE_CYC)) begin
               idle_q[p] <= idle_q[p] + `IDLE_W'(1);
            end
            link_q[p] <= next_link(link_q[p], rx_valid[p] | out_v_q[p],
                                   idle_q[p] == `IDLE_W'(`IDLE_CYC), pme_turn_off[p],
                                   device_state);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         dn_rst_n_q <= 2'h0;
         refclk_q <= `REFCLK_RST;
         idle_all_q <= 1'b0;
      end else begin
         dn_rst_n_q <= ~downstream_reset_ctl;
         refclk_q <= clock_buffer_powerdown ? 7'h00 :
                     {eeprom_refclk_en, `REFCLK_DEF};
         idle_all_q <= (rd == 6'h00) && (wr == 6'h00) && (out_v_q == 3'h0);
      end
   end

   always_comb begin
      for (int p = 0; p < `NP; p++) begin
         tx_data[p] = out_w_q[p][`DW-1:0];
         tx_sop[p] = out_w_q[p][`W_SOP];
         tx_eop[p] = out_w_q[p][`W_EOP];
         link_state[p] = link_q[p];
      end
   end

   assign tx_valid = out_v_q;
   assign rx_ready = rdy_q;
   assign rx_credit_vc0 = cr0_q;
   assign rx_credit_vc1 = cr1_q;
   assign downstream_port_reset_n = dn_rst_n_q;
   assign ref_clock_out_enable = refclk_q;
   assign buffers_idle = idle_all_q;

endmodule : three_port_packet_switch_core

/* dv/switch_core_monitor.sv */
`timescale 1ns/1ns
module switch_core_monitor (
   input wire logic clock,
   input wire logic srst,
   input wire logic system_reset_n,
   input wire logic [2:0] rx_ready,
   input wire logic [2:0][2:0] rx_credit_vc0,
   input wire logic [2:0] tx_valid,
   input wire logic [2:0][31:0] tx_data,
   input wire logic [2:0] tx_sop,
   input wire logic [2:0] tx_eop,
   input wire logic [2:0] tx_ready,
   input wire logic vc1_enable,
   input wire logic [2:1] downstream_reset_ctl,
   input wire logic [2:1] downstream_port_reset_n,
   input wire logic clock_buffer_powerdown,
   input wire logic [7:6] eeprom_refclk_en,
   input wire logic [7:1] ref_clock_out_enable
);
   logic rst;
   logic [2:0] in_pkt_q;
   logic [2:0] take;
   assign rst = srst | ~system_reset_n;
   assign take = tx_valid & tx_ready;
   // Egress ports currently in the middle of a packet
   always_ff @(posedge clock) begin
      if (rst) begin
         in_pkt_q <= 3'h0;
      end else begin
         in_pkt_q <= (in_pkt_q | (take & ~tx_eop)) & ~(take & tx_eop);
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   chk_hold_word: assert property (
      tx_valid[1] && !tx_ready[1] |=> tx_valid[1] && $stable(tx_data[1]))
      else $error("egress word changed while stalled");
   chk_no_merge: assert property ((tx_valid & in_pkt_q & tx_sop) == 3'h0)
      else $error("start word inside a packet");
   chk_no_split: assert property ((tx_valid & ~in_pkt_q & ~tx_sop) == 3'h0)
      else $error("packet without start word");
   chk_ready_credit: assert property (rx_ready[0] |-> rx_credit_vc0[0] != 3'h0)
      else $error("ready without free slot");
   chk_clk_off: assert property (
      clock_buffer_powerdown |=> ref_clock_out_enable == 7'h00)
      else $error("clock output on while powered down");
   chk_clk_on: assert property (
      !clock_buffer_powerdown |=> ref_clock_out_enable == {$past(eeprom_refclk_en), 5'h1f})
      else $error("clock output enables wrong");
   chk_dsrst_sw: assert property (
      1'b1 |=> downstream_port_reset_n == ~$past(downstream_reset_ctl))
      else $error("downstream reset not following control");
   chk_reset_outs: assert property (disable iff (1'b0)
      rst |=> downstream_port_reset_n == 2'h0 && tx_valid == 3'h0
      && ref_clock_out_enable == 7'h1f)
      else $error("outputs wrong during reset");
   chk_credit_init: assert property (disable iff (1'b0)
      rst ##1 !rst |=> rx_credit_vc0 == (vc1_enable ? 9'h092 : 9'h124))
      else $error("credits wrong after reset");
   cover property (take[0] && tx_eop[0]);
   cover property (tx_valid[1] && !tx_ready[1]);
   cover property (clock_buffer_powerdown);
endmodule : switch_core_monitor
bind three_port_packet_switch_core switch_core_monitor mon (.*);

/* dv/egress_sink.sv */
`timescale 1ns/1ns
module egress_sink (
   input wire logic clock,
   input wire logic [2:0] stall,
   input wire logic [2:0] tx_valid,
   input wire logic [2:0][31:0] tx_data,
   input wire logic [2:0] tx_sop,
   input wire logic [2:0] tx_eop,
   output logic [2:0] tx_ready
);
   logic [35:0] got[$];
   logic [1:0] phase_q = 2'h0;
   logic [2:0] ready_q = 3'h7;
   assign tx_ready = ready_q;
   // Stalled ports accept one word in four
   always @(posedge clock) begin
      phase_q <= phase_q + 2'h1;
      for (int p = 0; p < 3; p++) begin
         if (tx_valid[p] && ready_q[p]) begin
            got.push_back({p[1:0], tx_sop[p], tx_eop[p], tx_data[p]});
         end
         ready_q[p] <= !stall[p] || (phase_q == 2'h3);
      end
   end
endmodule : egress_sink

/* dv/test_three_port_packet_switch_core.sv */
`timescale 1ns/1ns
module test_three_port_packet_switch_core;
   import switch_pkg::*;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic system_reset_n = 1'b1;
   logic [2:0] rx_valid = 3'h0, rx_sop = 3'h0, rx_eop = 3'h0, stall = 3'h0;
   logic [2:0][31:0] rx_data = '0;
   logic [2:0] pme_turn_off = 3'h0;
   logic [2:0] rx_ready, tx_valid, tx_sop, tx_eop, tx_ready;
   logic [2:0][2:0] rx_credit_vc0, rx_credit_vc1;
   logic [2:0][31:0] tx_data;
   logic vc1_enable = 1'b1;
   logic peer_access_control = 1'b0;
   logic address_translation_service = 1'b0;
   logic [2:1][7:0] sec_bus = {8'h20, 8'h10};
   logic [2:1][7:0] sub_bus = {8'h2f, 8'h1f};
   logic [2:1][15:0] mem_base = {16'h2000, 16'h1000};
   logic [2:1][15:0] mem_limit = {16'h2fff, 16'h1fff};
   logic [11:0] lane_rx_active = 12'hfff;
   dstate_e device_state = D_D0;
   logic [2:1] downstream_reset_ctl = 2'h0;
   logic [2:1] downstream_port_reset_n;
   logic clock_buffer_powerdown = 1'b0;
   logic [7:6] eeprom_refclk_en = 2'h0;
   logic [7:1] ref_clock_out_enable;
   link_e [2:0] link_state;
   logic buffers_idle;
   int err_total = 0, n_checks = 0, cycles = 0;
   three_port_packet_switch_core uut (.*);
   egress_sink sink (.*);
   always #25 clock = ~clock;
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total = err_total + 1;
         complete_run();
      end
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      n_checks++;
      if (seen !== want) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic send(input int p, input logic [31:0] hdr, input int n);
      for (int k = 0; k < n; k++) begin
         rx_valid[p] <= 1'b1;
         rx_sop[p] <= (k == 0);
         rx_eop[p] <= (k == n - 1);
         rx_data[p] <= (k == 0) ? hdr : {p[7:0], 8'h0, k[15:0]};
         @(posedge clock);
         while (!rx_ready[p]) @(posedge clock);
      end
      rx_valid[p] <= 1'b0;
   endtask : send
   task automatic pop(input int p, output logic [35:0] w);
      w = 36'h0;
      for (int t = 0; t < 200; t++) begin
         foreach (sink.got[i]) begin
            if (sink.got[i][35:34] == p[1:0]) begin
               w = sink.got[i];
               sink.got.delete(i);
               return;
            end
         end
         @(posedge clock);
      end
   endtask : pop
   task automatic expect_pkt(input int p, input logic [31:0] hdr, input int src, input int n);
      logic [35:0] w;
      for (int k = 0; k < n; k++) begin
         pop(p, w);
         check(w, {p[1:0], k == 0, k == n - 1, (k == 0) ? hdr : {src[7:0], 8'h0, k[15:0]}});
      end
   endtask : expect_pkt
   initial begin
      repeat (20) @(posedge clock);
      srst <= 1'b0;
      repeat (2) @(posedge clock);
      check(rx_ready, 3'h7);
      check(ref_clock_out_enable, 7'h1f);
      check(downstream_port_reset_n, 2'h3);
      check(rx_credit_vc1, 9'h092);
      repeat (45) @(posedge clock);
      check(link_state[0], LK_L0S);
      send(0, 32'h0000_1234, 3);
      expect_pkt(1, 32'h0000_1234, 0, 3);
      fork
         send(0, 32'h0400_2500, 1);
         send(1, 32'h0000_5000, 4);
         send(2, 32'h0400_1100, 2);
      join
      expect_pkt(2, 32'h0400_2500, 0, 1);
      expect_pkt(0, 32'h0000_5000, 1, 4);
      expect_pkt(1, 32'h0400_1100, 2, 2);
      stall <= 3'h2;
      send(0, 32'h0000_1800, 6);
      expect_pkt(1, 32'h0000_1800, 0, 6);
      stall <= 3'h0;
      peer_access_control <= 1'b1;
      send(1, 32'h0000_2100, 1);
      expect_pkt(0, 32'h0000_2100, 1, 1);
      address_translation_service <= 1'b1;
      send(1, 32'h0200_2100, 1);
      expect_pkt(2, 32'h0200_2100, 1, 1);
      peer_access_control <= 1'b0;
      fork
         send(1, 32'h0000_7000, 1);
         send(2, 32'h1800_7000, 1);
      join
      expect_pkt(0, 32'h1800_7000, 2, 1);
      expect_pkt(0, 32'h0000_7000, 1, 1);
      for (int c = 0; c < 8; c++) begin
         send(1, {2'h0, c[2:0], 11'h0, 16'h2200}, 2);
         expect_pkt(2, {2'h0, c[2:0], 11'h0, 16'h2200}, 1, 2);
      end
      lane_rx_active <= 12'hf0f;
      fork
         send(0, 32'h0000_1400, 8);
         begin
            repeat (30) @(posedge clock);
            check(rx_ready[0], 1'b0);
            check(rx_ready[1], 1'b1);
            send(2, 32'h0000_3000, 1);
            expect_pkt(0, 32'h0000_3000, 2, 1);
            lane_rx_active <= 12'hfff;
         end
      join
      expect_pkt(1, 32'h0000_1400, 0, 8);
      clock_buffer_powerdown <= 1'b1;
      repeat (2) @(posedge clock);
      check(ref_clock_out_enable, 7'h00);
      check(buffers_idle, 1'b1);
      clock_buffer_powerdown <= 1'b0;
      eeprom_refclk_en <= 2'h3;
      downstream_reset_ctl <= 2'h2;
      pme_turn_off <= 3'h4;
      repeat (2) @(posedge clock);
      check(ref_clock_out_enable, 7'h7f);
      check(downstream_port_reset_n, 2'h1);
      check(link_state[2], LK_L23R);
      device_state <= D_D3COLD;
      repeat (2) @(posedge clock);
      check(link_state[2], LK_L23);
      check(link_state[0], LK_L1);
      system_reset_n <= 1'b0;
      vc1_enable <= 1'b0;
      repeat (2) @(posedge clock);
      check(downstream_port_reset_n, 2'h0);
      check(link_state[2], LK_L0);
      check(buffers_idle, 1'b0);
      system_reset_n <= 1'b1;
      device_state <= D_D0;
      pme_turn_off <= 3'h0;
      downstream_reset_ctl <= 2'h0;
      repeat (2) @(posedge clock);
      check(rx_credit_vc0, 9'h124);
      check(rx_credit_vc1, 9'h000);
      send(0, 32'h0000_2400, 5);
      expect_pkt(2, 32'h0000_2400, 0, 5);
      complete_run();
   end
endmodule : test_three_port_packet_switch_core
